// *** rtl/pfw_flash_ctrl.sv ***
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module pfw_flash_ctrl #(
    parameter int OP_CYCLES = pfw_pkg::OP_CYCLES_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic rst,
    pfw_if.flash_end bus,
    output logic busy,
    output logic [23:0] target_addr
);
    typedef enum logic [1:0] {
        KEY_NONE = 2'b00,
        KEY_FIRST = 2'b01,
        KEY_ARMED = 2'b10
    } pfw_key_e;

    logic [23:0] flash_mem [pfw_pkg::PANEL_WORDS];
    logic [23:0] latch_mem [pfw_pkg::ROW_WORDS];
    logic [15:0] ctl_ff;
    logic [15:0] addr_low_ff;
    logic [7:0] addr_high_ff;
    logic [7:0] page_ff;
    pfw_key_e key_ff;
    logic [23:0] op_cnt_ff;
    logic [1:0] tbl_cnt_ff;
    logic [15:0] sfr_rdata_ff;
    logic [15:0] tbl_rdata_ff;
    logic [23:0] tbl_addr;
    logic [11:0] tbl_word;
    logic [4:0] tbl_slot;
    logic [11:0] row_base;
    logic sw_wr;
    logic start_req;
    logic op_valid;
    logic op_end;
    logic tbl_fire;
    logic [23:0] rd_word;

    assign tbl_addr = {page_ff, bus.tbl_ea};
    assign tbl_word = tbl_addr[12:1];
    assign tbl_slot = tbl_addr[5:1];
    // Row index is word address bits 11..5, i.e. byte EA bits 12..6
    assign row_base = {addr_low_ff[12:6], 5'h00};
    assign target_addr = {addr_high_ff, addr_low_ff};
    // Writes are ignored while the array is busy; the core should be frozen anyway
    assign sw_wr = bus.sfr_wr & ~ctl_ff[pfw_pkg::CTL_WRITE_START_BIT];
    assign start_req = sw_wr && bus.sfr_addr == pfw_pkg::SFR_FLASH_OP_CONTROL
        && bus.sfr_wdata[pfw_pkg::CTL_WRITE_START_BIT];
    assign op_valid = ctl_ff[pfw_pkg::CTL_WRITE_ENABLE_BIT]
        && ctl_ff[5:0] == pfw_pkg::OP_ROW_PROGRAM_FLASH;
    assign op_end = ctl_ff[pfw_pkg::CTL_WRITE_START_BIT]
        && op_cnt_ff == 24'(OP_CYCLES - 1);
    assign bus.stall = ctl_ff[pfw_pkg::CTL_WRITE_START_BIT];
    assign busy = bus.stall;
    assign tbl_fire = bus.tbl_req && !bus.tbl_done && !bus.stall
        && tbl_cnt_ff == 2'(pfw_pkg::TBL_CYCLES - 1);
    assign bus.tbl_done = bus.tbl_req && tbl_cnt_ff == 2'(pfw_pkg::TBL_CYCLES);
    assign bus.sfr_rdata = sfr_rdata_ff;
    assign bus.tbl_rdata = tbl_rdata_ff;
    assign rd_word = flash_mem[tbl_word];

    // Control register and self-clearing start bit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctl_ff <= pfw_pkg::CTL_RESET;
        end else if (op_end) begin
            ctl_ff[pfw_pkg::CTL_WRITE_START_BIT] <= 1'b0;
        end else if (start_req) begin
            // Start needs armed key; error flag reports a keyed start of an invalid op
            if (key_ff == KEY_ARMED && op_valid) begin
                ctl_ff[pfw_pkg::CTL_WRITE_START_BIT] <= 1'b1;
                ctl_ff[pfw_pkg::CTL_WRITE_ERROR_BIT] <= 1'b0;
            end else if (key_ff == KEY_ARMED) begin
                ctl_ff[pfw_pkg::CTL_WRITE_ERROR_BIT] <= 1'b1;
            end
        end else if (sw_wr && bus.sfr_addr == pfw_pkg::SFR_FLASH_OP_CONTROL) begin
            ctl_ff <= (bus.sfr_wdata & pfw_pkg::CTL_SW_MASK)
                | (ctl_ff & ~pfw_pkg::CTL_SW_MASK);
        end
    end

    // Unlock key sequencer; any other write breaks the sequence
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            key_ff <= KEY_NONE;
        end else if (sw_wr) begin
            if (bus.sfr_addr != pfw_pkg::SFR_FLASH_UNLOCK_KEY) begin
                key_ff <= KEY_NONE;
            end else if (bus.sfr_wdata[7:0] == pfw_pkg::UNLOCK_KEY_FIRST) begin
                key_ff <= KEY_FIRST;
            end else if (key_ff == KEY_FIRST
                && bus.sfr_wdata[7:0] == pfw_pkg::UNLOCK_KEY_SECOND) begin
                key_ff <= KEY_ARMED;
            end else begin
                key_ff <= KEY_NONE;
            end
        end else if (tbl_fire && bus.tbl_write) begin
            key_ff <= KEY_NONE;
        end
    end

    // Target address: table capture or direct write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            addr_low_ff <= pfw_pkg::ADDR_LOW_RESET;
            addr_high_ff <= pfw_pkg::ADDR_HIGH_RESET;
        end else if (tbl_fire) begin
            addr_low_ff <= tbl_addr[15:0];
            addr_high_ff <= tbl_addr[23:16];
        end else if (sw_wr) begin
            if (bus.sfr_addr == pfw_pkg::SFR_FLASH_TARGET_ADDR_LOW) begin
                addr_low_ff <= bus.sfr_wdata;
            end
            if (bus.sfr_addr == pfw_pkg::SFR_FLASH_TARGET_ADDR_HIGH) begin
                addr_high_ff <= bus.sfr_wdata[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            page_ff <= pfw_pkg::TABLE_PAGE_RESET;
        end else if (sw_wr && bus.sfr_addr == pfw_pkg::SFR_TABLE_PAGE_REGISTER) begin
            page_ff <= bus.sfr_wdata[7:0];
        end
    end

    // Register read port; key reads as zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sfr_rdata_ff <= 16'h0000;
        end else if (bus.sfr_rd) begin
            case (bus.sfr_addr)
                pfw_pkg::SFR_FLASH_OP_CONTROL: sfr_rdata_ff <= ctl_ff;
                pfw_pkg::SFR_FLASH_TARGET_ADDR_LOW: sfr_rdata_ff <= addr_low_ff;
                pfw_pkg::SFR_FLASH_TARGET_ADDR_HIGH: sfr_rdata_ff <= {8'h00, addr_high_ff};
                pfw_pkg::SFR_TABLE_PAGE_REGISTER: sfr_rdata_ff <= {8'h00, page_ff};
                default: sfr_rdata_ff <= 16'h0000;
            endcase
        end
    end

    // Two-cycle table access timer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tbl_cnt_ff <= 2'h0;
        end else if (!bus.tbl_req || bus.tbl_done) begin
            tbl_cnt_ff <= 2'h0;
        end else if (!bus.stall) begin
            tbl_cnt_ff <= tbl_cnt_ff + 2'h1;
        end
    end

    // Table read data
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tbl_rdata_ff <= 16'h0000;
        end else if (tbl_fire && !bus.tbl_write) begin
            if (!bus.tbl_high) begin
                if (bus.tbl_byte) begin
                    tbl_rdata_ff <= {8'h00, tbl_addr[0] ? rd_word[15:8] : rd_word[7:0]};
                end else begin
                    tbl_rdata_ff <= rd_word[15:0];
                end
            end else begin
                // Odd high byte is the phantom byte and reads zero
                tbl_rdata_ff <= {8'h00, (bus.tbl_byte && tbl_addr[0]) ? 8'h00 : rd_word[23:16]};
            end
        end
    end

    // Write latches; only the latch changes, never the array
    always_ff @(posedge sys_clk) begin
        if (tbl_fire && bus.tbl_write) begin
            if (!bus.tbl_high && bus.tbl_byte) begin
                if (tbl_addr[0]) begin
                    latch_mem[tbl_slot][15:8] <= bus.tbl_wdata[7:0];
                end else begin
                    latch_mem[tbl_slot][7:0] <= bus.tbl_wdata[7:0];
                end
            end else if (!bus.tbl_high) begin
                latch_mem[tbl_slot][15:0] <= bus.tbl_wdata;
            end else if (!(bus.tbl_byte && tbl_addr[0])) begin
                latch_mem[tbl_slot][23:16] <= bus.tbl_wdata[7:0];
            end
        end
    end

    // Operation timer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            op_cnt_ff <= 24'h000000;
        end else if (!bus.stall || op_end) begin
            op_cnt_ff <= 24'h000000;
        end else begin
            op_cnt_ff <= op_cnt_ff + 24'h000001;
        end
    end

    // Array update at the end of the cycle, one row per operation
    always_ff @(posedge sys_clk) begin
        if (op_end) begin
            for (int i = 0; i < pfw_pkg::ROW_WORDS; i++) begin
                if (ctl_ff[pfw_pkg::CTL_OP_ERASE_BIT]) begin
                    flash_mem[row_base + 12'(i)] <= pfw_pkg::ERASED_WORD;
                end else begin
                    flash_mem[row_base + 12'(i)] <= latch_mem[i];
                end
            end
        end
    end
endmodule : pfw_flash_ctrl
`default_nettype wire

// *** rtl/pfw_pkg.sv ***
package pfw_pkg;
    // Special function register addresses on the core's register bus
    localparam logic [15:0] SFR_FLASH_OP_CONTROL = 16'h0760;
    localparam logic [15:0] SFR_FLASH_TARGET_ADDR_LOW = 16'h0762;
    localparam logic [15:0] SFR_FLASH_TARGET_ADDR_HIGH = 16'h0764;
    localparam logic [15:0] SFR_FLASH_UNLOCK_KEY = 16'h0766;
    localparam logic [15:0] SFR_TABLE_PAGE_REGISTER = 16'h0032;

    // Control register layout
    localparam int CTL_WRITE_START_BIT = 15;
    localparam int CTL_WRITE_ENABLE_BIT = 14;
    localparam int CTL_WRITE_ERROR_BIT = 13;
    localparam int CTL_OP_ERASE_BIT = 6;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] CTL_SW_MASK = 16'h417F;
    localparam logic [5:0] OP_ROW_PROGRAM_FLASH = 6'h01;
    localparam logic [15:0] ADDR_LOW_RESET = 16'h0000;
    localparam logic [7:0] ADDR_HIGH_RESET = 8'h00;
    localparam logic [7:0] TABLE_PAGE_RESET = 8'h00;

    // Unlock key bytes
    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;

    // Array geometry
    localparam int ROW_WORDS = 32;
    localparam int PANEL_ROWS = 128;
    localparam int PANEL_WORDS = ROW_WORDS * PANEL_ROWS;
    localparam logic [23:0] ERASED_WORD = 24'hFFFFFF;

    // Timing at 125 MHz
    localparam int CLK_PERIOD_NS = 8;
    localparam int OP_TIME_US = 2000;
    localparam int OP_CYCLES_DEFAULT = OP_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int TBL_CYCLES = 2;
    localparam int NOP_GAP_CYCLES = 2;

    // Host register map on Avalon-MM
    localparam logic [4:0] HOST_REG_CMD = 5'h00;
    localparam logic [4:0] HOST_REG_ADDR = 5'h04;
    localparam logic [4:0] HOST_REG_WDATA = 5'h08;
    localparam logic [4:0] HOST_REG_RDATA = 5'h0C;
    localparam logic [4:0] HOST_REG_STATUS = 5'h10;

    typedef enum logic [2:0] {
        CMD_SFR_WRITE = 3'b000,
        CMD_SFR_READ = 3'b001,
        CMD_TBL_READ = 3'b010,
        CMD_TBL_WRITE = 3'b011
    } pfw_cmd_e;
endpackage : pfw_pkg

// *** rtl/pfw_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface pfw_if;
    logic sfr_wr;
    logic sfr_rd;
    logic [15:0] sfr_addr;
    logic [15:0] sfr_wdata;
    logic [15:0] sfr_rdata;
    logic tbl_req;
    logic tbl_write;
    logic tbl_high;
    logic tbl_byte;
    logic [15:0] tbl_ea;
    logic [15:0] tbl_wdata;
    logic tbl_done;
    logic [15:0] tbl_rdata;
    logic stall;

    modport flash_end (
        input sfr_wr, sfr_rd, sfr_addr, sfr_wdata, tbl_req, tbl_write, tbl_high,
        input tbl_byte, tbl_ea, tbl_wdata,
        output sfr_rdata, tbl_done, tbl_rdata, stall
    );
    modport core_end (
        output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, tbl_req, tbl_write, tbl_high,
        output tbl_byte, tbl_ea, tbl_wdata,
        input sfr_rdata, tbl_done, tbl_rdata, stall
    );
endinterface : pfw_if
`default_nettype wire

// *** rtl/pfw_core_proxy.sv ***
`timescale 1ns/100ps
`default_nettype none
module pfw_core_proxy (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    pfw_if.core_end bus
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SFR = 3'b001,
        ST_SFR_DATA = 3'b010,
        ST_TBL = 3'b011,
        ST_GAP = 3'b100
    } pfw_st_e;

    pfw_st_e st_ff;
    logic [4:0] cmd_ff;
    logic [15:0] addr_ff;
    logic [15:0] wdata_ff;
    logic [15:0] rdata_ff;
    logic [1:0] gap_ff;
    logic ack_ff;
    logic [31:0] avs_readdata_ff;
    logic cmd_go;
    logic busy;

    assign busy = st_ff != ST_IDLE || bus.stall;
    assign cmd_go = avs_write && ack_ff && avs_address == pfw_pkg::HOST_REG_CMD;
    // Command write waits while an earlier access is still open
    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
    assign avs_readdata = avs_readdata_ff;
    assign bus.sfr_wr = st_ff == ST_SFR && cmd_ff[2:0] == pfw_pkg::CMD_SFR_WRITE;
    assign bus.sfr_rd = st_ff == ST_SFR && cmd_ff[2:0] == pfw_pkg::CMD_SFR_READ;
    assign bus.sfr_addr = addr_ff;
    assign bus.sfr_wdata = wdata_ff;
    assign bus.tbl_req = st_ff == ST_TBL;
    assign bus.tbl_write = cmd_ff[2:0] == pfw_pkg::CMD_TBL_WRITE;
    assign bus.tbl_byte = cmd_ff[3];
    assign bus.tbl_high = cmd_ff[4];
    assign bus.tbl_ea = addr_ff;
    assign bus.tbl_wdata = wdata_ff;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read || avs_write) && !ack_ff
                && !(avs_write && avs_address == pfw_pkg::HOST_REG_CMD && busy);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_readdata_ff <= 32'h00000000;
        end else if (avs_read && !ack_ff) begin
            case (avs_address)
                pfw_pkg::HOST_REG_CMD: avs_readdata_ff <= {27'h0000000, cmd_ff};
                pfw_pkg::HOST_REG_ADDR: avs_readdata_ff <= {16'h0000, addr_ff};
                pfw_pkg::HOST_REG_WDATA: avs_readdata_ff <= {16'h0000, wdata_ff};
                pfw_pkg::HOST_REG_RDATA: avs_readdata_ff <= {16'h0000, rdata_ff};
                pfw_pkg::HOST_REG_STATUS: avs_readdata_ff <= {30'h00000000, bus.stall, busy};
                default: avs_readdata_ff <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            addr_ff <= 16'h0000;
            wdata_ff <= 16'h0000;
        end else if (avs_write && ack_ff && !busy) begin
            if (avs_address == pfw_pkg::HOST_REG_ADDR) begin
                addr_ff <= avs_writedata[15:0];
            end
            if (avs_address == pfw_pkg::HOST_REG_WDATA) begin
                wdata_ff <= avs_writedata[15:0];
            end
        end
    end

    // Sequencer; nothing issues while the flash end stalls the core
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_ff <= ST_IDLE;
            cmd_ff <= 5'h00;
            rdata_ff <= 16'h0000;
            gap_ff <= 2'h0;
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    if (cmd_go) begin
                        cmd_ff <= avs_writedata[4:0];
                        st_ff <= avs_writedata[1] ? ST_TBL : ST_SFR;
                    end
                end
                ST_SFR: begin
                    st_ff <= bus.sfr_rd ? ST_SFR_DATA : ST_GAP;
                    gap_ff <= 2'(pfw_pkg::NOP_GAP_CYCLES);
                end
                ST_SFR_DATA: begin
                    rdata_ff <= bus.sfr_rdata;
                    st_ff <= ST_IDLE;
                end
                ST_TBL: begin
                    if (bus.tbl_done) begin
                        if (!bus.tbl_write) begin
                            rdata_ff <= bus.tbl_rdata;
                        end
                        st_ff <= ST_IDLE;
                    end
                end
                ST_GAP: begin
                    if (!bus.stall) begin
                        gap_ff <= gap_ff - 2'h1;
                        if (gap_ff == 2'h1) begin
                            st_ff <= ST_IDLE;
                        end
                    end
                end
                default: st_ff <= ST_IDLE;
            endcase
        end
    end
endmodule : pfw_core_proxy
`default_nettype wire

// *** tb/pfw_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module pfw_assertions #(
    parameter int OP_CYCLES = 20
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [15:0] sfr_addr,
    input wire logic [15:0] sfr_wdata,
    input wire logic [15:0] sfr_rdata,
    input wire logic tbl_req,
    input wire logic tbl_write,
    input wire logic [15:0] tbl_ea,
    input wire logic tbl_done,
    input wire logic stall,
    input wire logic busy,
    input wire logic [23:0] target_addr
);
    int stall_cnt_ff;
    logic key_first_ff;
    logic armed_ff;
    logic [7:0] page_ff;
    logic key_wr;
    logic start_wr;
    assign key_wr = sfr_wr && sfr_addr == pfw_pkg::SFR_FLASH_UNLOCK_KEY;
    assign start_wr = sfr_wr && sfr_addr == pfw_pkg::SFR_FLASH_OP_CONTROL && sfr_wdata[15];

    always_ff @(posedge sys_clk) begin
        if (rst || !stall) begin
            stall_cnt_ff <= 0;
        end else begin
            stall_cnt_ff <= stall_cnt_ff + 1;
        end
    end
    // Table writes break the key sequence as well
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            key_first_ff <= 1'b0;
            armed_ff <= 1'b0;
        end else if ((sfr_wr && !stall) || (tbl_done && tbl_write)) begin
            key_first_ff <= key_wr && sfr_wdata[7:0] == pfw_pkg::UNLOCK_KEY_FIRST;
            armed_ff <= key_first_ff && key_wr && sfr_wdata[7:0] == pfw_pkg::UNLOCK_KEY_SECOND;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            page_ff <= 8'h00;
        end else if (sfr_wr && !stall && sfr_addr == pfw_pkg::SFR_TABLE_PAGE_REGISTER) begin
            page_ff <= sfr_wdata[7:0];
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_stall_is_busy: assert property (sfr_rd && sfr_addr == pfw_pkg::SFR_FLASH_OP_CONTROL
        |=> sfr_rdata[15] == $past(busy) && stall == busy)
        else $error("stall differs from start bit");
    a_op_full_length: assert property ($fell(stall) |-> stall_cnt_ff == OP_CYCLES)
        else $error("operation length wrong");
    a_op_no_overrun: assert property (stall |-> stall_cnt_ff < OP_CYCLES)
        else $error("operation overran");
    a_start_needs_key: assert property ($rose(stall) |-> $past(armed_ff) && $past(start_wr))
        else $error("operation started without key");
    a_start_launches: assert property (start_wr && armed_ff && !stall && sfr_wdata[14]
        && sfr_wdata[5:0] == pfw_pkg::OP_ROW_PROGRAM_FLASH |=> stall)
        else $error("keyed start ignored");
    a_tbl_two_cycles: assert property ($rose(tbl_req) && !stall |->
        !tbl_done ##1 !tbl_done ##1 tbl_done)
        else $error("table op not done in two cycles");
    a_tbl_single_done: assert property (tbl_done |=> !tbl_done)
        else $error("table done longer than one cycle");
    a_ea_low_capture: assert property (tbl_done |-> target_addr[15:0] == tbl_ea)
        else $error("low address not captured");
    a_ea_high_capture: assert property (tbl_done |-> target_addr[23:16] == page_ff)
        else $error("high address not captured");
    a_direct_addr_wr: assert property (sfr_wr && !stall
        && sfr_addr == pfw_pkg::SFR_FLASH_TARGET_ADDR_LOW |=> target_addr[15:0] == $past(sfr_wdata))
        else $error("direct address write lost");
    a_key_reads_zero: assert property (sfr_rd && sfr_addr == pfw_pkg::SFR_FLASH_UNLOCK_KEY
        |=> sfr_rdata == 16'h0000)
        else $error("key register readable");

    c_op_start: cover property ($rose(stall));
    c_op_end: cover property ($fell(stall));
    c_tbl_write: cover property (tbl_done && tbl_write);
endmodule : pfw_assertions
`default_nettype wire

// *** tb/program_flash_self_write_ctrl_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module program_flash_self_write_ctrl_tb;
    localparam int OPC = 20;
    localparam logic [4:0] C_SW = 5'h00, C_SR = 5'h01, C_TRL = 5'h02, C_TWL = 5'h03;
    localparam logic [4:0] C_TRH = 5'h12, C_TWH = 5'h13;
    localparam logic [15:0] A_CTL = pfw_pkg::SFR_FLASH_OP_CONTROL;
    localparam logic [15:0] A_LO = pfw_pkg::SFR_FLASH_TARGET_ADDR_LOW;
    localparam logic [15:0] A_HI = pfw_pkg::SFR_FLASH_TARGET_ADDR_HIGH;
    localparam logic [15:0] A_KEY = pfw_pkg::SFR_FLASH_UNLOCK_KEY;
    localparam logic [15:0] A_PG = pfw_pkg::SFR_TABLE_PAGE_REGISTER;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic busy;
    logic [23:0] target_addr;
    int err_count = 0;
    int n_tests = 0;
    logic [31:0] exp_q[$];
    string nm_q[$];
    logic [31:0] m_exp;
    string m_nm;
    logic [31:0] rnd_state = 32'h63;
    logic [31:0] rd;
    logic [15:0] lo[32];
    logic [7:0] hi[32];
    logic [7:0] page;
    logic [15:0] base;

    always #4 sys_clk = ~sys_clk;
    pfw_if bus_if ();
    pfw_flash_ctrl #(.OP_CYCLES(OPC)) pfw_flash_ctrl_inst (.sys_clk(sys_clk), .rst(rst),
        .bus(bus_if), .busy(busy), .target_addr(target_addr));
    pfw_core_proxy pfw_core_proxy_inst (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus(bus_if));
    pfw_assertions #(.OP_CYCLES(OPC)) pfw_assertions_inst (.sys_clk(sys_clk), .rst(rst),
        .sfr_wr(bus_if.sfr_wr), .sfr_rd(bus_if.sfr_rd), .sfr_addr(bus_if.sfr_addr),
        .sfr_wdata(bus_if.sfr_wdata), .sfr_rdata(bus_if.sfr_rdata), .tbl_req(bus_if.tbl_req),
        .tbl_write(bus_if.tbl_write), .tbl_ea(bus_if.tbl_ea), .tbl_done(bus_if.tbl_done),
        .stall(bus_if.stall), .busy(busy), .target_addr(target_addr));

    function logic [31:0] xs();
        rnd_state = rnd_state ^ (rnd_state << 13);
        rnd_state = rnd_state ^ (rnd_state >> 17);
        rnd_state = rnd_state ^ (rnd_state << 5);
        return rnd_state;
    endfunction : xs

    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // Waitrequest is judged only at a rising edge; release right after it
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : av

    task automatic op(input logic [4:0] cmd, input logic [15:0] a, input logic [15:0] d);
        logic [31:0] q;
        av(1'b1, pfw_pkg::HOST_REG_ADDR, {16'h0000, a}, q);
        av(1'b1, pfw_pkg::HOST_REG_WDATA, {16'h0000, d}, q);
        av(1'b1, pfw_pkg::HOST_REG_CMD, {27'h0, cmd}, q);
        do av(1'b0, pfw_pkg::HOST_REG_STATUS, 32'h0, q); while (q[1:0] !== 2'b00);
    endtask : op

    task automatic check(input logic [4:0] cmd, input logic [15:0] a, input logic [15:0] e,
        input string nm);
        logic [31:0] q;
        op(cmd, a, 16'h0000);
        exp_q.push_back({16'h0000, e});
        nm_q.push_back(nm);
        av(1'b0, pfw_pkg::HOST_REG_RDATA, 32'h0, q);
    endtask : check

    task automatic start(input logic [15:0] ctl);
        op(C_SW, A_CTL, ctl & 16'h7FFF);
        op(C_SW, A_KEY, {8'h00, pfw_pkg::UNLOCK_KEY_FIRST});
        op(C_SW, A_KEY, {8'h00, pfw_pkg::UNLOCK_KEY_SECOND});
        op(C_SW, A_CTL, ctl);
    endtask : start

    task tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    always @(negedge sys_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0
            && avs_address == pfw_pkg::HOST_REG_RDATA) begin
            m_exp = exp_q.pop_front();
            m_nm = nm_q.pop_front();
            `CHK(m_nm, m_exp, avs_readdata)
        end
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        err_count++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        check(C_SR, A_CTL, pfw_pkg::CTL_RESET, "ctl reset");
        check(C_SR, A_LO, pfw_pkg::ADDR_LOW_RESET, "addr low reset");
        check(C_SR, A_HI, {8'h00, pfw_pkg::ADDR_HIGH_RESET}, "addr high reset");
        check(C_SR, A_PG, {8'h00, pfw_pkg::TABLE_PAGE_RESET}, "page reset");
        op(C_SW, A_KEY, 16'h0055);
        check(C_SR, A_KEY, 16'h0000, "key read");
        rd = xs();
        op(C_SW, A_LO, rd[15:0]);
        check(C_SR, A_LO, rd[15:0], "addr low");
        op(C_SW, A_HI, {8'h00, rd[23:16]});
        check(C_SR, A_HI, {8'h00, rd[23:16]}, "addr high");
        op(C_SW, A_CTL, rd[31:16] | 16'h8000);
        check(C_SR, A_CTL, pfw_pkg::CTL_RESET, "ctl unkeyed");
        op(C_SW, A_CTL, rd[31:16] & 16'h7FFF);
        check(C_SR, A_CTL, rd[31:16] & pfw_pkg::CTL_SW_MASK, "ctl mask");
        rd = xs();
        page = rd[15:8];
        base = {3'b000, rd[6:0], 6'h00};
        op(C_SW, A_PG, {8'h00, page});
        op(C_SW, A_LO, base);
        start(16'hC041);
        check(C_SR, A_CTL, 16'h4041, "erase end");
        for (int i = 0; i < 32; i++) begin
            check(C_TRL, base + 16'(2 * i), 16'hFFFF, "erased low");
            check(C_TRH, base + 16'(2 * i), 16'h00FF, "erased high");
        end
        // Ascending, row aligned load; upper byte of high data must be ignored
        for (int i = 0; i < 32; i++) begin
            rd = xs();
            lo[i] = rd[15:0];
            hi[i] = rd[23:16];
            op(C_TWL, base + 16'(2 * i), lo[i]);
            op(C_TWH, base + 16'(2 * i), rd[31:16]);
        end
        check(C_SR, A_LO, base + 16'h003E, "ea low");
        check(C_SR, A_HI, {8'h00, page}, "ea high");
        start(16'hC001);
        check(C_SR, A_CTL, 16'h4001, "program end");
        for (int i = 0; i < 32; i++) begin
            check(C_TRL, base + 16'(2 * i), lo[i], "word low");
            check(C_TRH, base + 16'(2 * i), {8'h00, hi[i]}, "word high");
        end
        op(C_SW, A_KEY, 16'h0055);
        op(C_SW, A_LO, base);
        op(C_SW, A_KEY, 16'h00AA);
        op(C_SW, A_CTL, 16'hC001);
        check(C_SR, A_CTL, 16'h4001, "broken key");
        check(C_TRL, base, lo[0], "row kept");
        start(16'hC002);
        check(C_SR, A_CTL, 16'h6002, "bad op");
        tally_and_finish();
    end
endmodule : program_flash_self_write_ctrl_tb
`default_nettype wire
